// >>> include/dmc_pkg.sv
// Summary of operation
// - instruction cache word-index width is a build parameter, 9 to 14 bits
// - data cache word-index width is a build parameter, 11 to 14 bits
// - tag width = cacheable byte-address width minus cache byte-address width
// - each tag entry holds tag, one valid bit and one lock bit
// - both caches are direct mapped: index selects the entry, upper bits compared
// - non-cacheable fetches bypass the cache and go straight to memory
// - a hit needs the valid bit set and a matching stored tag
// - instruction hit raises fetch ready together with the cached word
// - instruction miss waits for memory, then writes word and tag into place
// - instruction caching switched by its enable bit in the status register
// - disabling keeps contents; software and debug may overwrite instruction entries
// - a locked entry is never replaced by a fill; conflicting addresses stay uncached
// - link mode fills four-word lines critical word first; bus mode one word
// - bus-mode store stalls until done; link-mode store is posted
// - data addresses between low and high bounds are cacheable, others not
// - write-through: stores go to memory, update on hit, no allocate on miss
// - data load hit raises data ready together with the cached word
// - data load miss waits for memory, then writes word and tag into place
// - data caching switched by its own enable bit in the status register
// - enable bits changed inside an interrupt handler are restored on return
// - software and debug write paths update data cache entries
package dmc_pkg;
  localparam logic [11:0] REG_MSTAT = 12'h000;
  localparam logic [11:0] REG_WADDR = 12'h004;
  localparam logic [11:0] REG_WDATA = 12'h008;
  localparam logic [11:0] REG_WCTRL = 12'h00c;
  localparam logic [11:0] REG_STAT = 12'h010;
  localparam int MS_IC_BIT = 0;
  localparam int MS_DC_BIT = 1;
  localparam int WC_SEL_BIT = 0;
  localparam int WC_LOCK_BIT = 1;
  localparam int WC_VALID_BIT = 2;
  localparam int ST_PEND_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_LINK_BIT = 2;
  localparam logic [1:0] LINE_LAST = 2'h3;
  localparam int IC_IDX_DEF = 10;
  localparam int IC_AW_DEF = 16;
  localparam logic [31:0] IC_LOW_DEF = 32'h0030_0000;
  localparam logic [31:0] IC_HIGH_DEF = 32'h0030_ffff;
  localparam int DC_IDX_DEF = 11;
  localparam int DC_AW_DEF = 14;
  localparam logic [31:0] DC_LOW_DEF = 32'h0040_0000;
  localparam logic [31:0] DC_HIGH_DEF = 32'h0040_3fff;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_IRD = 2'b01,
    ST_DRD = 2'b10,
    ST_DWR = 2'b11
  } dmc_fsm_t;

  typedef struct packed {
    dmc_fsm_t state;
    logic [1:0] cnt;
    logic fill;
    logic burst;
    logic posted;
    logic memReq;
    logic memWe;
    logic [31:0] memAddr;
    logic [31:0] memWdata;
    logic iRdy;
    logic [31:0] iData;
    logic dRdy;
    logic [31:0] dData;
    logic icEn;
    logic dcEn;
    logic savIc;
    logic savDc;
    logic [31:0] wAddr;
    logic [31:0] wData;
    logic wSel;
    logic wLock;
    logic wValid;
    logic swPend;
    logic dbgAck;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } dmc_regs_t;

  localparam dmc_regs_t DMC_REGS_RST = '0;
endpackage

// >>> hw/dmc_caches.sv
// The address map and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
module dmc_caches import dmc_pkg::*; #(
  parameter int IC_IDX_W = IC_IDX_DEF,
  parameter int IC_AW = IC_AW_DEF,
  parameter logic [31:0] IC_LOW = IC_LOW_DEF,
  parameter logic [31:0] IC_HIGH = IC_HIGH_DEF,
  parameter int DC_IDX_W = DC_IDX_DEF,
  parameter int DC_AW = DC_AW_DEF,
  parameter logic [31:0] DC_LOW = DC_LOW_DEF,
  parameter logic [31:0] DC_HIGH = DC_HIGH_DEF,
  parameter bit LINK_SEL = 1'b0
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic irqEnter,
  input wire logic irqReturn,
  input wire logic ifReq,
  input wire logic [31:0] ifAddr,
  output logic ifReady,
  output logic [31:0] ifData,
  input wire logic dReq,
  input wire logic dWe,
  input wire logic [31:0] dAddr,
  input wire logic [31:0] dWdata,
  output logic dReady,
  output logic [31:0] dRdata,
  input wire logic dbgWrReq,
  input wire logic dbgWrSel,
  input wire logic [31:0] dbgWrAddr,
  input wire logic [31:0] dbgWrData,
  input wire logic dbgWrLock,
  output logic dbgWrAck,
  output logic memReq,
  output logic memWe,
  output logic memLine,
  output logic [31:0] memAddr,
  output logic [31:0] memWdata,
  input wire logic memAck,
  input wire logic memRvalid,
  input wire logic [31:0] memRdata,
  output logic icEnable,
  output logic dcEnable
);
  localparam int IC_TW = IC_AW - IC_IDX_W - 2;
  localparam int DC_TW = DC_AW - DC_IDX_W - 2;
  localparam int IC_DEPTH = 1 << IC_IDX_W;
  localparam int DC_DEPTH = 1 << DC_IDX_W;

  dmc_regs_t regs_ff;
  dmc_regs_t nxt_regs;

  logic [31:0] icDataMem [IC_DEPTH];
  logic [IC_TW-1:0] icTagMem [IC_DEPTH];
  logic icValidMem [IC_DEPTH];
  logic icLockMem [IC_DEPTH];
  logic [31:0] dcDataMem [DC_DEPTH];
  logic [DC_TW-1:0] dcTagMem [DC_DEPTH];
  logic dcValidMem [DC_DEPTH];
  logic dcLockMem [DC_DEPTH];

  logic icWe;
  logic [IC_IDX_W-1:0] icWIdx;
  logic [IC_TW-1:0] icWTag;
  logic [31:0] icWData;
  logic icWValid;
  logic icWLock;
  logic dcWe;
  logic [DC_IDX_W-1:0] dcWIdx;
  logic [DC_TW-1:0] dcWTag;
  logic [31:0] dcWData;
  logic dcWValid;
  logic dcWLock;

  function automatic logic inRange(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

  function automatic logic [IC_IDX_W-1:0] icIdx(input logic [31:0] a);
    logic [31:0] o;
    o = a - IC_LOW;
    return o[IC_IDX_W+1:2];
  endfunction

  function automatic logic [IC_TW-1:0] icTag(input logic [31:0] a);
    logic [31:0] o;
    o = a - IC_LOW;
    return o[IC_AW-1:IC_IDX_W+2];
  endfunction

  function automatic logic [DC_IDX_W-1:0] dcIdx(input logic [31:0] a);
    logic [31:0] o;
    o = a - DC_LOW;
    return o[DC_IDX_W+1:2];
  endfunction

  function automatic logic [DC_TW-1:0] dcTag(input logic [31:0] a);
    logic [31:0] o;
    o = a - DC_LOW;
    return o[DC_AW-1:DC_IDX_W+2];
  endfunction

  // lookups read the arrays asynchronously so a hit answers on the next edge
  logic [IC_IDX_W-1:0] fIdx;
  logic fCached;
  logic fHit;
  logic [DC_IDX_W-1:0] lIdx;
  logic lCached;
  logic lHit;
  logic [31:0] fillAddr;
  logic [IC_IDX_W-1:0] fillIcIdx;
  logic [DC_IDX_W-1:0] fillDcIdx;
  logic fillIcBlocked;
  logic fillDcBlocked;
  logic dAccept;
  logic fAccept;
  logic maintBusy;

  assign fIdx = icIdx(ifAddr);
  assign fCached = regs_ff.icEn && inRange(ifAddr, IC_LOW, IC_HIGH);
  assign fHit = icValidMem[fIdx] && (icTagMem[fIdx] == icTag(ifAddr));
  assign lIdx = dcIdx(dAddr);
  assign lCached = regs_ff.dcEn && inRange(dAddr, DC_LOW, DC_HIGH);
  assign lHit = dcValidMem[lIdx] && (dcTagMem[lIdx] == dcTag(dAddr));
  // line words wrap inside the aligned four-word line
  assign fillAddr = {regs_ff.memAddr[31:4], 2'(regs_ff.memAddr[3:2] + regs_ff.cnt), 2'b00};
  assign fillIcIdx = icIdx(fillAddr);
  assign fillDcIdx = dcIdx(fillAddr);
  assign fillIcBlocked = icLockMem[fillIcIdx] && (icTagMem[fillIcIdx] != icTag(fillAddr));
  assign fillDcBlocked = dcLockMem[fillDcIdx] && (dcTagMem[fillDcIdx] != dcTag(fillAddr));
  assign maintBusy = (dbgWrReq && !regs_ff.dbgAck) || regs_ff.swPend;
  // ready stays high for the cycle the requester still holds its request
  assign dAccept = (regs_ff.state == ST_IDLE) && !maintBusy && dReq && !regs_ff.dRdy;
  assign fAccept = (regs_ff.state == ST_IDLE) && !maintBusy && !(dReq && !regs_ff.dRdy) && ifReq && !regs_ff.iRdy;

  always_comb begin
    nxt_regs = regs_ff;
    nxt_regs.iRdy = 1'b0;
    nxt_regs.dRdy = 1'b0;
    nxt_regs.dbgAck = 1'b0;
    nxt_regs.pready = 1'b0;
    nxt_regs.pslverr = 1'b0;
    icWe = 1'b0;
    icWIdx = fillIcIdx;
    icWTag = icTag(fillAddr);
    icWData = memRdata;
    icWValid = 1'b1;
    icWLock = icLockMem[fillIcIdx];
    dcWe = 1'b0;
    dcWIdx = fillDcIdx;
    dcWTag = dcTag(fillAddr);
    dcWData = memRdata;
    dcWValid = 1'b1;
    dcWLock = dcLockMem[fillDcIdx];
    case (regs_ff.state)
      ST_IDLE: begin
        if (dbgWrReq && !regs_ff.dbgAck) begin
          nxt_regs.dbgAck = 1'b1;
          if (dbgWrSel) begin
            dcWe = inRange(dbgWrAddr, DC_LOW, DC_HIGH);
            dcWIdx = dcIdx(dbgWrAddr);
            dcWTag = dcTag(dbgWrAddr);
            dcWData = dbgWrData;
            dcWLock = dbgWrLock;
          end else begin
            icWe = inRange(dbgWrAddr, IC_LOW, IC_HIGH);
            icWIdx = icIdx(dbgWrAddr);
            icWTag = icTag(dbgWrAddr);
            icWData = dbgWrData;
            icWLock = dbgWrLock;
          end
        end else if (regs_ff.swPend) begin
          nxt_regs.swPend = 1'b0;
          if (regs_ff.wSel) begin
            dcWe = inRange(regs_ff.wAddr, DC_LOW, DC_HIGH);
            dcWIdx = dcIdx(regs_ff.wAddr);
            dcWTag = dcTag(regs_ff.wAddr);
            dcWData = regs_ff.wData;
            dcWValid = regs_ff.wValid;
            dcWLock = regs_ff.wLock;
          end else begin
            icWe = inRange(regs_ff.wAddr, IC_LOW, IC_HIGH);
            icWIdx = icIdx(regs_ff.wAddr);
            icWTag = icTag(regs_ff.wAddr);
            icWData = regs_ff.wData;
            icWValid = regs_ff.wValid;
            icWLock = regs_ff.wLock;
          end
        end else if (dAccept) begin
          nxt_regs.memAddr = {dAddr[31:2], 2'b00};
          nxt_regs.cnt = 2'h0;
          if (dWe) begin
            // write-through; a miss allocates nothing
            nxt_regs.memReq = 1'b1;
            nxt_regs.memWe = 1'b1;
            nxt_regs.memWdata = dWdata;
            nxt_regs.burst = 1'b0;
            nxt_regs.fill = 1'b0;
            nxt_regs.posted = LINK_SEL;
            nxt_regs.dRdy = LINK_SEL;
            nxt_regs.state = ST_DWR;
            if (lCached && lHit) begin
              dcWe = 1'b1;
              dcWIdx = lIdx;
              dcWTag = dcTag(dAddr);
              dcWData = dWdata;
              dcWLock = dcLockMem[lIdx];
            end
          end else if (lCached && lHit) begin
            nxt_regs.dRdy = 1'b1;
            nxt_regs.dData = dcDataMem[lIdx];
          end else begin
            // uncached loads take a single word and never touch the arrays
            nxt_regs.memReq = 1'b1;
            nxt_regs.memWe = 1'b0;
            nxt_regs.fill = lCached;
            nxt_regs.burst = LINK_SEL && lCached;
            nxt_regs.state = ST_DRD;
          end
        end else if (fAccept) begin
          nxt_regs.memAddr = {ifAddr[31:2], 2'b00};
          nxt_regs.cnt = 2'h0;
          if (fCached && fHit) begin
            nxt_regs.iRdy = 1'b1;
            nxt_regs.iData = icDataMem[fIdx];
          end else begin
            nxt_regs.memReq = 1'b1;
            nxt_regs.memWe = 1'b0;
            nxt_regs.fill = fCached;
            nxt_regs.burst = LINK_SEL && fCached;
            nxt_regs.state = ST_IRD;
          end
        end
      end
      ST_IRD, ST_DRD: begin
        if (memRvalid) begin
          nxt_regs.memReq = 1'b0;
          nxt_regs.cnt = 2'(regs_ff.cnt + 2'h1);
          if (regs_ff.cnt == 2'h0) begin
            // critical word goes to the pipeline first
            if (regs_ff.state == ST_IRD) begin
              nxt_regs.iRdy = 1'b1;
              nxt_regs.iData = memRdata;
            end else begin
              nxt_regs.dRdy = 1'b1;
              nxt_regs.dData = memRdata;
            end
          end
          if (regs_ff.state == ST_IRD) begin
            icWe = regs_ff.fill && !fillIcBlocked;
          end else begin
            dcWe = regs_ff.fill && !fillDcBlocked;
          end
          if (!regs_ff.burst || regs_ff.cnt == LINE_LAST) begin
            nxt_regs.state = ST_IDLE;
          end
        end
      end
      ST_DWR: begin
        if (memAck) begin
          nxt_regs.memReq = 1'b0;
          nxt_regs.memWe = 1'b0;
          nxt_regs.dRdy = !regs_ff.posted;
          nxt_regs.state = ST_IDLE;
        end
      end
      default: nxt_regs.state = ST_IDLE;
    endcase
    if (psel && !penable) begin
      nxt_regs.pready = 1'b1;
      nxt_regs.prdata = 32'h0;
      case (paddr)
        REG_MSTAT: begin
          nxt_regs.prdata[MS_IC_BIT] = regs_ff.icEn;
          nxt_regs.prdata[MS_DC_BIT] = regs_ff.dcEn;
        end
        REG_WADDR: nxt_regs.prdata = regs_ff.wAddr;
        REG_WDATA: nxt_regs.prdata = regs_ff.wData;
        REG_WCTRL: begin
          nxt_regs.prdata[WC_SEL_BIT] = regs_ff.wSel;
          nxt_regs.prdata[WC_LOCK_BIT] = regs_ff.wLock;
          nxt_regs.prdata[WC_VALID_BIT] = regs_ff.wValid;
        end
        REG_STAT: begin
          nxt_regs.prdata[ST_PEND_BIT] = regs_ff.swPend;
          nxt_regs.prdata[ST_BUSY_BIT] = regs_ff.state != ST_IDLE;
          nxt_regs.prdata[ST_LINK_BIT] = LINK_SEL;
        end
        default: nxt_regs.pslverr = 1'b1;
      endcase
    end
    if (psel && penable && regs_ff.pready && pwrite && !regs_ff.pslverr) begin
      case (paddr)
        REG_MSTAT: begin
          nxt_regs.icEn = pwdata[MS_IC_BIT];
          nxt_regs.dcEn = pwdata[MS_DC_BIT];
        end
        REG_WADDR: nxt_regs.wAddr = pwdata;
        REG_WDATA: nxt_regs.wData = pwdata;
        REG_WCTRL: begin
          nxt_regs.wSel = pwdata[WC_SEL_BIT];
          nxt_regs.wLock = pwdata[WC_LOCK_BIT];
          nxt_regs.wValid = pwdata[WC_VALID_BIT];
          nxt_regs.swPend = 1'b1;
        end
        default: ;
      endcase
    end
    // return restores the enables even if the handler rewrote them
    if (irqEnter) begin
      nxt_regs.savIc = regs_ff.icEn;
      nxt_regs.savDc = regs_ff.dcEn;
    end
    if (irqReturn) begin
      nxt_regs.icEn = regs_ff.savIc;
      nxt_regs.dcEn = regs_ff.savDc;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      regs_ff <= DMC_REGS_RST;
    end else begin
      regs_ff <= nxt_regs;
    end
  end

  // tag entry: tag, valid, lock; disable never clears them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < IC_DEPTH; i++) begin
        icValidMem[i] <= 1'b0;
        icLockMem[i] <= 1'b0;
      end
      for (int j = 0; j < DC_DEPTH; j++) begin
        dcValidMem[j] <= 1'b0;
        dcLockMem[j] <= 1'b0;
      end
    end else begin
      if (icWe) begin
        icValidMem[icWIdx] <= icWValid;
        icLockMem[icWIdx] <= icWLock;
      end
      if (dcWe) begin
        dcValidMem[dcWIdx] <= dcWValid;
        dcLockMem[dcWIdx] <= dcWLock;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (icWe) begin
      icDataMem[icWIdx] <= icWData;
      icTagMem[icWIdx] <= icWTag;
    end
    if (dcWe) begin
      dcDataMem[dcWIdx] <= dcWData;
      dcTagMem[dcWIdx] <= dcWTag;
    end
  end

  assign prdata = regs_ff.prdata;
  assign pready = regs_ff.pready;
  assign pslverr = regs_ff.pslverr;
  assign ifReady = regs_ff.iRdy;
  assign ifData = regs_ff.iData;
  assign dReady = regs_ff.dRdy;
  assign dRdata = regs_ff.dData;
  assign dbgWrAck = regs_ff.dbgAck;
  assign memReq = regs_ff.memReq;
  assign memWe = regs_ff.memWe;
  assign memLine = regs_ff.burst;
  assign memAddr = regs_ff.memAddr;
  assign memWdata = regs_ff.memWdata;
  assign icEnable = regs_ff.icEn;
  assign dcEnable = regs_ff.dcEn;

  logic [31:0] fHitWord;
  assign fHitWord = icDataMem[fIdx];

  a_ifetch_hit: assert property (@(posedge clk) disable iff (!resetn)
    (fAccept && fCached && fHit) |=> (ifReady && ifData == $past(fHitWord) && !memReq))
    else $error("fetch hit not answered from cache");
  a_lock_hold: assert property (@(posedge clk) disable iff (!resetn)
    (regs_ff.state == ST_IRD && memRvalid && fillIcBlocked) |-> !icWe)
    else $error("locked instruction entry overwritten by fill");
  a_ifill_write: assert property (@(posedge clk) disable iff (!resetn)
    (regs_ff.state == ST_IRD && memRvalid && regs_ff.fill && !fillIcBlocked) |-> (icWe && icWTag == icTag(fillAddr)))
    else $error("instruction miss word not stored");
  a_store_through: assert property (@(posedge clk) disable iff (!resetn)
    (dAccept && dWe) |=> (memReq && memWe && memWdata == $past(dWdata)))
    else $error("store not sent to memory");
  a_store_noalloc: assert property (@(posedge clk) disable iff (!resetn)
    (dAccept && dWe && !lHit) |-> !dcWe)
    else $error("store miss allocated a line");
  a_load_bypass: assert property (@(posedge clk) disable iff (!resetn)
    (dAccept && !dWe && !lCached) |=> (memReq && !regs_ff.fill && !memLine))
    else $error("uncached load took the cache path");
  a_bus_stall: assert property (@(posedge clk) disable iff (!resetn)
    (regs_ff.state == ST_DWR && !regs_ff.posted && !memAck) |=> !dReady)
    else $error("bus store released before completion");
  a_line_single: assert property (@(posedge clk) disable iff (!resetn)
    (regs_ff.state == ST_DRD && memRvalid && !memLine) |=> (regs_ff.state == ST_IDLE))
    else $error("single-word line did not end after one word");
  a_irq_restore: assert property (@(posedge clk) disable iff (!resetn)
    irqReturn |=> (icEnable == $past(regs_ff.savIc) && dcEnable == $past(regs_ff.savDc)))
    else $error("enables not restored on handler return");
  a_dload_hit: assert property (@(posedge clk) disable iff (!resetn)
    (dAccept && !dWe && lCached && lHit) |=> (dReady && !memReq))
    else $error("data hit not answered from cache");
endmodule

// >>> dv/dmc_mem_model.sv
`timescale 1ns/1ps
// far-side memory: word data is a pure function of the address, so any stale hit shows
module dmc_mem_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic memReq,
  input wire logic memWe,
  input wire logic memLine,
  input wire logic [31:0] memAddr,
  input wire logic [31:0] memWdata,
  output logic memAck,
  output logic memRvalid,
  output logic [31:0] memRdata,
  output int rdCount,
  output int wrCount,
  output logic [31:0] lastWaddr,
  output logic [31:0] lastWdata
);
  int phase;
  int dly;
  int beats;
  logic we;
  logic [31:0] addr;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase <= 0;
      memAck <= 1'b0;
      memRvalid <= 1'b0;
      memRdata <= 32'h0;
      rdCount <= 0;
      wrCount <= 0;
    end else begin
      memAck <= 1'b0;
      memRvalid <= 1'b0;
      // no stale word left on the bus between beats
      memRdata <= ~memRdata;
      if (phase == 0 && memReq) begin
        phase <= 1;
        we <= memWe;
        addr <= memAddr;
        lastWdata <= memWdata;
        beats <= memLine ? 4 : 1;
        // prompt and slow answers alternate
        dly <= (rdCount + wrCount) % 2 == 0 ? 1 : 5;
        rdCount <= rdCount + (memWe ? 0 : 1);
        wrCount <= wrCount + (memWe ? 1 : 0);
      end else if (phase == 1 && dly > 1) begin
        dly <= dly - 1;
      end else if (phase == 1 && we) begin
        memAck <= 1'b1;
        lastWaddr <= addr;
        phase <= 2;
      end else if (phase == 1) begin
        memRvalid <= 1'b1;
        memRdata <= {addr[15:0], ~addr[15:0]};
        addr <= {addr[31:4], addr[3:2] + 2'h1, 2'b00};
        beats <= beats - 1;
        if (beats == 1) begin
          phase <= 2;
        end
      end else if (phase == 2 && !memReq) begin
        phase <= 0;
      end
    end
  end
endmodule

// >>> dv/direct_mapped_inst_data_caches_test.sv
`timescale 1ns/1ps
module direct_mapped_inst_data_caches_test import dmc_pkg::*;;
  localparam logic [31:0] IA = 32'h0030_0010;
  localparam logic [31:0] IB = 32'h0030_1010;
  localparam logic [31:0] IL = 32'h0030_0020;
  localparam logic [31:0] ILC = 32'h0030_1020;
  localparam logic [31:0] DA = 32'h0040_0008; // no local block-RAM inside the cacheable data range
  localparam logic [31:0] DB = 32'h0040_2008;
  localparam logic [31:0] DT = 32'h0040_3ffc;
  localparam logic [31:0] DC = 32'h0040_0100;
  localparam logic [31:0] LA = 32'h0040_0138;
  logic clk, resetn, psel, penable, pwrite, pready, pslverr, irqEnter, irqReturn, ifReq, ifReady;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, ifAddr, ifData, dAddr, dWdata, dRdata, dbgWrAddr, dbgWrData;
  logic [31:0] memAddr, memWdata, memRdata, lastWaddr, lastWdata;
  logic dReq, dWe, dReady, dbgWrReq, dbgWrSel, dbgWrLock, dbgWrAck, memReq, memWe, memLine, memAck, memRvalid;
  logic icEnable, dcEnable;
  int rdCount, wrCount, n_fail, n_tests;
  // second instance in link mode, with its own data request and memory; APB and interrupt inputs are shared
  logic lReq, lReady, lMemReq, lMemWe, lMemLine, lMemAck, lMemRvalid;
  logic [31:0] lRdata, lMemAddr, lMemWdata, lMemRdata, lWaddr, lWdata;
  int lRd, lWr;
  dmc_caches DUT (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .irqEnter, .irqReturn, .ifReq, .ifAddr, .ifReady, .ifData, .dReq, .dWe, .dAddr, .dWdata, .dReady, .dRdata,
    .dbgWrReq, .dbgWrSel, .dbgWrAddr, .dbgWrData, .dbgWrLock, .dbgWrAck, .memReq, .memWe, .memLine, .memAddr,
    .memWdata, .memAck, .memRvalid, .memRdata, .icEnable, .dcEnable);
  dmc_mem_model mem (.clk, .resetn, .memReq, .memWe, .memLine, .memAddr, .memWdata, .memAck, .memRvalid,
    .memRdata, .rdCount, .wrCount, .lastWaddr, .lastWdata);
  dmc_caches #(.LINK_SEL(1'b1)) DUT_LINK (.clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata(),
    .pready(), .pslverr(), .irqEnter, .irqReturn, .ifReq(1'b0), .ifAddr, .ifReady(), .ifData(), .dReq(lReq), .dWe,
    .dAddr, .dWdata, .dReady(lReady), .dRdata(lRdata), .dbgWrReq(1'b0), .dbgWrSel, .dbgWrAddr, .dbgWrData,
    .dbgWrLock, .dbgWrAck(), .memReq(lMemReq), .memWe(lMemWe), .memLine(lMemLine), .memAddr(lMemAddr),
    .memWdata(lMemWdata), .memAck(lMemAck), .memRvalid(lMemRvalid), .memRdata(lMemRdata), .icEnable(),
    .dcEnable());
  dmc_mem_model lMem (.clk, .resetn, .memReq(lMemReq), .memWe(lMemWe), .memLine(lMemLine), .memAddr(lMemAddr),
    .memWdata(lMemWdata), .memAck(lMemAck), .memRvalid(lMemRvalid), .memRdata(lMemRdata), .rdCount(lRd),
    .wrCount(lWr), .lastWaddr(lWaddr), .lastWdata(lWdata));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] mw(input logic [31:0] a);
    return {a[15:0], ~a[15:0]};
  endfunction
  function automatic logic rdy(input int w);
    return w == 0 ? pready : w == 1 ? ifReady : w == 2 ? dReady : w == 3 ? dbgWrAck :
      w == 4 ? lReady : !lMemReq;
  endfunction
  task automatic end_sim();
    if (n_fail == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  // bounded wait; a hung handshake ends the run
  task automatic waitHi(input int w);
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (rdy(w) !== 1'b1 && k < 100);
    if (rdy(w) !== 1'b1) begin
      chk("handshake", 32'h1, 32'h0);
      end_sim();
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    waitHi(0);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // idle cycle so the next setup never lands in the release time step
    @(posedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0, r, e);
    if (!xe) chk("prdata", x, r);
    chk("pslverr", {31'h0, xe}, {31'h0, e});
  endtask
  task automatic acc(input bit isD, input bit we, input logic [31:0] a, input logic [31:0] d, input int nRd);
    int c0;
    int w0;
    c0 = rdCount;
    w0 = wrCount;
    if (isD) begin
      dReq <= 1'b1;
      dWe <= we;
      dAddr <= a;
      dWdata <= d;
    end else begin
      ifReq <= 1'b1;
      ifAddr <= a;
    end
    waitHi(isD ? 2 : 1);
    if (!we) chk(isD ? "dRdata" : "ifData", d, isD ? dRdata : ifData);
    if (we) chk("wAddr", a, lastWaddr);
    if (we) chk("wData", d, lastWdata);
    dReq <= 1'b0;
    ifReq <= 1'b0;
    @(posedge clk);
    chk("memReads", 32'(nRd), 32'(rdCount - c0));
    chk("memWrites", {31'h0, we}, 32'(wrCount - w0));
  endtask
  // link-mode data access; a posted store answers while memory is still busy
  task automatic lac(input bit we, input logic [31:0] a, input logic [31:0] d, input int nRd);
    int c0;
    int w0;
    c0 = lRd;
    w0 = lWr;
    lReq <= 1'b1;
    dWe <= we;
    dAddr <= a;
    dWdata <= d;
    waitHi(4);
    if (we) chk("posted", 32'h1, {31'h0, lMemReq});
    if (!we) chk("lRdata", d, lRdata);
    lReq <= 1'b0;
    waitHi(5);
    if (we) chk("lWaddr", a, lWaddr);
    if (we) chk("lWdata", d, lWdata);
    chk("lReads", 32'(nRd), 32'(lRd - c0));
    chk("lWrites", {31'h0, we}, 32'(lWr - w0));
  endtask
  task automatic dbg(input logic sel, input logic [31:0] a, input logic [31:0] d, input logic lock);
    dbgWrReq <= 1'b1;
    dbgWrSel <= sel;
    dbgWrAddr <= a;
    dbgWrData <= d;
    dbgWrLock <= lock;
    waitHi(3);
    dbgWrReq <= 1'b0;
    @(posedge clk);
  endtask
  initial begin
    logic [31:0] a;
    int i;
    resetn = 1'b0;
    {psel, penable, pwrite, irqEnter, irqReturn, ifReq, dReq, dWe, dbgWrReq, dbgWrSel, dbgWrLock, lReq} = '0;
    {paddr, pwdata, ifAddr, dAddr, dWdata, dbgWrAddr, dbgWrData} = '0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    rd(REG_MSTAT, 32'h0, 1'b0);
    rd(12'h014, 32'h0, 1'b1);
    wr(12'h014, 32'h3);
    rd(REG_MSTAT, 32'h0, 1'b0);
    acc(0, 0, IA, mw(IA), 1);
    acc(0, 0, IA, mw(IA), 1);
    wr(REG_MSTAT, 32'h3);
    rd(REG_MSTAT, 32'h3, 1'b0);
    acc(0, 0, IA, mw(IA), 1);
    acc(0, 0, IA, mw(IA), 0);
    acc(0, 0, IB, mw(IB), 1);
    acc(0, 0, IA, mw(IA), 1);
    for (i = 0; i < 4; i++) begin
      a = i[1] ? 32'h0031_0000 : 32'h002f_fffc;
      acc(0, 0, a, mw(a), 1);
    end
    wr(REG_MSTAT, 32'h2);
    acc(0, 0, IA, mw(IA), 1);
    wr(REG_MSTAT, 32'h3);
    acc(0, 0, IA, mw(IA), 0);
    wr(REG_WADDR, IL);
    wr(REG_WDATA, 32'h1234_5678);
    wr(REG_WCTRL, 32'h6);
    acc(0, 0, IL, 32'h1234_5678, 0);
    for (i = 0; i < 2; i++) acc(0, 0, ILC, mw(ILC), 1);
    acc(0, 0, IL, 32'h1234_5678, 0);
    acc(1, 0, DA, mw(DA), 1);
    acc(1, 0, DA, mw(DA), 0);
    acc(1, 1, DA, 32'hcafe_f00d, 0);
    acc(1, 0, DA, 32'hcafe_f00d, 0);
    acc(1, 1, DB, 32'h0bad_0001, 0);
    acc(1, 0, DA, 32'hcafe_f00d, 0);
    acc(1, 0, DB, mw(DB), 1);
    for (i = 0; i < 4; i++) begin
      a = i[1] ? 32'h0040_4000 : 32'h003f_fffc;
      acc(1, 0, a, mw(a), 1);
    end
    acc(1, 0, DT, mw(DT), 1);
    acc(1, 0, DT, mw(DT), 0);
    wr(REG_MSTAT, 32'h1);
    acc(1, 0, DB, mw(DB), 1);
    wr(REG_MSTAT, 32'h3);
    acc(1, 0, DB, mw(DB), 0);
    dbg(1'b1, DC, 32'h0bad_beef, 1'b1);
    for (i = 0; i < 2; i++) acc(1, 0, DC ^ 32'h2000, mw(DC ^ 32'h2000), 1);
    acc(1, 0, DC, 32'h0bad_beef, 0);
    dbg(1'b0, IB, 32'h5555_aaaa, 1'b0);
    acc(0, 0, IB, 32'h5555_aaaa, 0);
    irqEnter <= 1'b1;
    @(posedge clk);
    irqEnter <= 1'b0;
    wr(REG_MSTAT, 32'h0);
    rd(REG_MSTAT, 32'h0, 1'b0);
    irqReturn <= 1'b1;
    @(posedge clk);
    irqReturn <= 1'b0;
    @(posedge clk);
    rd(REG_MSTAT, 32'h3, 1'b0);
    chk("enables", 32'h3, {30'h0, dcEnable, icEnable});
    lac(1'b0, LA, mw(LA), 1);
    for (i = 0; i < 4; i++) begin
      a = {LA[31:4], 2'(i), 2'b00};
      lac(1'b0, a, mw(a), 0);
    end
    lac(1'b1, LA, 32'h7e57_0001, 0);
    lac(1'b0, LA, 32'h7e57_0001, 0);
    end_sim();
  end
endmodule
